// ===== src/pmis_top.sv
// indirect extended access, link drop cause and status summary registers
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "pmis_map.svh"
// What this block does
// - command bits 15-14 pick address, data, increment on both, on writes.
// - device select bits 4-0 route every indirect access to that space.
// - select 11111 reaches vendor space, indexes below EXT_DEPTH, 0x04D1 at most.
// - select 00011 reaches MMD3, select 00111 reaches MMD7.
// - any other select is ignored and changes no extended register.
// - address/data is the pointer under command 0, else the data port.
// - link drop causes latch when enabled, clear on read of the register.
// - cause bits 8-4, several may latch at once: energy, SNR, MLT3, receive errors, descrambler.
// - summary bit 14 shows swapped pairs.
// - bit 13 latches receive errors, cleared by error counter read.
// - bit 12 mirrors inverted polarity flag, summary read keeps it.
// - bit 11 latches false carrier, cleared by its counter read.
// - bits 10 and 9 show signal detect and descrambler lock.
// - bit 8 mirrors the page received flag.
// - bit 7 shows a pending internal interrupt.
// - bit 6 latches remote fault, cleared by reset or basic status read.
// - bit 5 shows jabber in 10 Mbps only, summary read keeps it.
// - bit 4 shows negotiation complete.
// - bit 3 shows MII loopback enabled.
// - bit 1 shows speed, 1 for 10 Mbps.
// - bit 0 mirrors link flag, summary read keeps it.
module pmis_top #(
  parameter int unsigned EXT_DEPTH = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic [4:0]           fld_enable,
  input  wire pmis_pkg::pmis_event_t ev,
  input  wire pmis_pkg::pmis_level_t lvl,
  input  wire pmis_pkg::pmis_rdclr_t rdclr
);
  import pmis_pkg::*;

  localparam int unsigned AW = (EXT_DEPTH < 2) ? 1 : $clog2(EXT_DEPTH);
  localparam logic [15:0] DEPTH16 = 16'(EXT_DEPTH);

  // storage beyond the vendor limit would be unreachable
  if (EXT_DEPTH < 2 || EXT_DEPTH > 1234) begin : g_bad_depth
    $error("pmis_top: EXT_DEPTH must be 2 to 1234");
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // select code to space
  function automatic logic [2:0] dev_sel(input logic [4:0] d);
    logic [2:0] r;
    r = 3'h0;
    if (d == `PMIS_DEV_VEND) begin
      r = 3'h4;
    end else if (d == `PMIS_DEV_MMD3) begin
      r = 3'h5;
    end else if (d == `PMIS_DEV_MMD7) begin
      r = 3'h6;
    end
    return r;
  endfunction : dev_sel

  function automatic logic [5:0] addr_idx(input logic [31:0] a);
    logic [5:0] r;
    r = `PMIS_IDX_NONE;
    if (a[31:8] == 24'h000000 && a[1:0] == 2'h0) begin
      r = a[7:2];
    end
    return r;
  endfunction : addr_idx

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  pmis_bus_st_t st_reg;
  logic [5:0]   a_idx_reg;
  logic         wr_pend_reg;
  logic [31:0]  hrdata_reg;
  logic         acc;
  logic         rd_fire;
  logic         wr_fire;

  // limitation: a transfer offered while ce is low is not taken
  assign acc       = hsel && htrans[1] && hready;
  // one wait state on reads so a write just before is seen
  assign hreadyout = (st_reg != PMIS_RD_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign rd_fire   = ce && (st_reg == PMIS_RD_WAIT);
  assign wr_fire   = ce && wr_pend_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg      <= PMIS_IDLE;
      wr_pend_reg <= 1'b0;
      a_idx_reg   <= `PMIS_IDX_NONE;
    end else if (ce) begin
      wr_pend_reg <= acc && hwrite;
      if (acc) begin
        a_idx_reg <= addr_idx(haddr);
      end
      case (st_reg)
        PMIS_IDLE: begin
          if (acc && !hwrite) begin
            st_reg <= PMIS_RD_WAIT;
          end
        end
        PMIS_RD_WAIT: begin
          st_reg <= PMIS_RD_RESP;
        end
        PMIS_RD_RESP: begin
          st_reg <= (acc && !hwrite) ? PMIS_RD_WAIT : PMIS_IDLE;
        end
        default: begin
          st_reg <= PMIS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // indirect extended access
  // ---------------------------------------------------------------
  pmis_eac_t         eac_reg;
  logic [2:0][15:0]  ptr_reg;
  logic [15:0]       mem_reg [3][EXT_DEPTH];
  logic [2:0]        sel;
  logic              sv;
  logic [1:0]        si;
  logic [15:0]       cur_ptr;
  logic              in_rng;
  logic              ead_wr;
  logic              ead_rd;
  logic              data_cmd;
  logic              inc;
  logic [15:0]       ead_val;

  assign sel      = dev_sel(eac_reg.dev);
  assign sv       = sel[2];
  assign si       = sel[1:0];
  assign cur_ptr  = ptr_reg[si];
  // depth check keeps every stored index within the vendor limit
  assign in_rng   = (cur_ptr < DEPTH16);
  assign ead_wr   = wr_fire && (a_idx_reg == `PMIS_IDX_EAD);
  assign ead_rd   = rd_fire && (a_idx_reg == `PMIS_IDX_EAD);
  assign data_cmd = (eac_reg.cmd != `PMIS_CMD_ADDR);
  assign inc = (eac_reg.cmd == `PMIS_CMD_INC_RW && (ead_wr || ead_rd)) ||
               (eac_reg.cmd == `PMIS_CMD_INC_WR && ead_wr);

  always_ff @(posedge clk) begin
    if (rst) begin
      eac_reg <= '0;
    end else if (wr_fire && a_idx_reg == `PMIS_IDX_EAC) begin
      eac_reg.cmd <= hwdata[`PMIS_CMD_HI:`PMIS_CMD_LO];
      eac_reg.dev <= hwdata[`PMIS_DEV_HI:`PMIS_DEV_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= '0;
    end else if (ce && sv) begin
      if (ead_wr && !data_cmd) begin
        ptr_reg[si] <= hwdata[15:0];
      end else if (inc) begin
        ptr_reg[si] <= cur_ptr + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int s = 0; s < 3; s++) begin
        for (int i = 0; i < EXT_DEPTH; i++) begin
          mem_reg[s][i] <= 16'h0000;
        end
      end
    end else if (ce && sv && ead_wr && data_cmd && in_rng) begin
      mem_reg[si][cur_ptr[AW-1:0]] <= hwdata[15:0];
    end
  end

  always_comb begin
    ead_val = 16'h0000;
    if (sv && !data_cmd) begin
      ead_val = cur_ptr;
    end else if (sv && in_rng) begin
      ead_val = mem_reg[si][cur_ptr[AW-1:0]];
    end
  end

  // ---------------------------------------------------------------
  // link drop causes and latched status
  // ---------------------------------------------------------------
  logic [4:0]  fld_reg;
  logic [4:0]  fld_set;
  logic        fld_rd;
  logic        rx_err_reg;
  logic        fc_reg;
  logic        rf_reg;
  logic [15:0] summ_val;

  assign fld_set = ev.fld_drop & fld_enable;
  assign fld_rd  = rd_fire && (a_idx_reg == `PMIS_IDX_FLD);

  always_ff @(posedge clk) begin
    if (rst) begin
      fld_reg <= 5'h00;
    end else if (ce) begin
      fld_reg <= (fld_reg & ~{5{fld_rd}}) | fld_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_err_reg <= 1'b0;
    end else if (ce) begin
      rx_err_reg <= (rx_err_reg && !rdclr.rx_err_cnt_rd) || ev.rx_err;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fc_reg <= 1'b0;
    end else if (ce) begin
      fc_reg <= (fc_reg && !rdclr.false_carr_rd) || ev.false_carrier;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rf_reg <= 1'b0;
    end else if (ce) begin
      rf_reg <= (rf_reg && !rdclr.basic_stat_rd) || ev.remote_fault;
    end
  end

  assign summ_val = {1'b0,
                     lvl.mdix_swapped,
                     rx_err_reg,
                     lvl.pol_inverted,
                     fc_reg,
                     lvl.sig_detect,
                     lvl.descr_lock,
                     lvl.page_rcvd,
                     lvl.intr_pending,
                     rf_reg,
                     lvl.jabber && lvl.speed_10,
                     lvl.an_done,
                     lvl.mii_loopback,
                     lvl.full_duplex,
                     lvl.speed_10,
                     lvl.link_up};

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata_reg <= 32'h00000000;
    end else if (rd_fire) begin
      if (a_idx_reg == `PMIS_IDX_EAC) begin
        hrdata_reg <= {16'h0000, eac_reg.cmd, 9'h000, eac_reg.dev};
      end else if (a_idx_reg == `PMIS_IDX_EAD) begin
        hrdata_reg <= {16'h0000, ead_val};
      end else if (a_idx_reg == `PMIS_IDX_FLD) begin
        hrdata_reg <= {23'h000000, fld_reg, 4'h0};
      end else if (a_idx_reg == `PMIS_IDX_SUM) begin
        hrdata_reg <= {16'h0000, summ_val};
      end else begin
        hrdata_reg <= 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence rd_req_s;
    acc && !hwrite && ce;
  endsequence

  sequence rd_done_s;
    !hreadyout ##1 hreadyout;
  endsequence

  rd_wait_a: assert property (
    @(posedge clk) disable iff (rst)
    rd_req_s ##1 ce |-> rd_done_s)
    else $error("read answer not after one wait state");

  fld_set_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && fld_set != 5'h00 |=> (fld_reg & $past(fld_set)) == $past(fld_set))
    else $error("enabled link drop cause not latched");

  fld_clr_a: assert property (
    @(posedge clk) disable iff (rst)
    fld_rd && fld_set == 5'h00 |=> fld_reg == 5'h00)
    else $error("link drop causes not cleared by read");

  // a cause may only leave through a read, never by itself
  fld_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !fld_rd && fld_reg != 5'h00 |=>
      (fld_reg & $past(fld_reg)) == $past(fld_reg))
    else $error("link drop cause lost without read");

  rxerr_latch_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && ev.rx_err ##1 !(ce && rdclr.rx_err_cnt_rd) |=> rx_err_reg)
    else $error("receive error latch not held");

  fc_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && rdclr.false_carr_rd && !ev.false_carrier |=> !fc_reg)
    else $error("false carrier latch not cleared");

  rf_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && rdclr.basic_stat_rd && !ev.remote_fault |=> !rf_reg)
    else $error("remote fault not cleared by status read");

  sum_read_a: assert property (
    @(posedge clk) disable iff (rst)
    rd_fire && a_idx_reg == `PMIS_IDX_SUM |=>
      hrdata[15:0] == $past(summ_val) && hreadyout)
    else $error("summary read data wrong");

  addr_cmd_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && sv && ead_wr && !data_cmd |=>
      ptr_reg[$past(si)] == $past(hwdata[15:0]))
    else $error("pointer not loaded under address command");

  post_inc_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && sv && inc |=> ptr_reg[$past(si)] == $past(cur_ptr) + 16'h0001)
    else $error("pointer not incremented");

  bad_dev_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && !sv && (ead_wr || ead_rd) |=> $stable(ptr_reg))
    else $error("ignored select changed a pointer");

endmodule : pmis_top

// ===== src/pmis_map.svh
// register indexes, field positions, codes and reset values of the block
`ifndef PMIS_MAP_SVH
`define PMIS_MAP_SVH
// register indexes; byte address is four times the index
`define PMIS_IDX_EAC 6'h0d
`define PMIS_IDX_EAD 6'h0e
`define PMIS_IDX_FLD 6'h0f
`define PMIS_IDX_SUM 6'h10
`define PMIS_IDX_NONE 6'h3f
// extended access control fields
`define PMIS_CMD_HI 15
`define PMIS_CMD_LO 14
`define PMIS_DEV_HI 4
`define PMIS_DEV_LO 0
// fast link drop cause field
`define PMIS_FLD_HI 8
`define PMIS_FLD_LO 4
// command codes
`define PMIS_CMD_ADDR 2'h0
`define PMIS_CMD_DATA 2'h1
`define PMIS_CMD_INC_RW 2'h2
`define PMIS_CMD_INC_WR 2'h3
// target device select codes
`define PMIS_DEV_VEND 5'h1f
`define PMIS_DEV_MMD3 5'h03
`define PMIS_DEV_MMD7 5'h07
`define PMIS_VEND_MAX 16'h04d1
// reset values
`define PMIS_RST_EAC 16'h0000
`define PMIS_RST_EAD 16'h0000
`define PMIS_RST_FLD 16'h0000
`define PMIS_RST_SUM 16'h0002
`endif

// ===== src/pmis_pkg.sv
// types shared by the management slice and its bench
package pmis_pkg;
  typedef enum logic [1:0] {
    PMIS_IDLE    = 2'b00,
    PMIS_RD_WAIT = 2'b01,
    PMIS_RD_RESP = 2'b11
  } pmis_bus_st_t;
  typedef struct packed {
    logic       rx_err;
    logic       false_carrier;
    logic       remote_fault;
    logic [4:0] fld_drop;
  } pmis_event_t;
  typedef struct packed {
    logic mdix_swapped;
    logic pol_inverted;
    logic sig_detect;
    logic descr_lock;
    logic page_rcvd;
    logic intr_pending;
    logic jabber;
    logic an_done;
    logic mii_loopback;
    logic full_duplex;
    logic speed_10;
    logic link_up;
  } pmis_level_t;
  typedef struct packed {
    logic rx_err_cnt_rd;
    logic false_carr_rd;
    logic basic_stat_rd;
  } pmis_rdclr_t;
  typedef struct packed {
    logic [1:0] cmd;
    logic [4:0] dev;
  } pmis_eac_t;
endpackage : pmis_pkg

// ===== tb/pmis_host.sv
// management host model: single AHB-Lite word transfers
`timescale 1ns/1ps
module pmis_host (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // address phase held until ready, then data phase held
  task automatic xfer(input logic [5:0] idx, input logic w,
                      input logic [15:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : pmis_host

// ===== tb/testbench.sv
// self-checking bench with a behavioural register model
`timescale 1ns/1ps
`include "pmis_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import pmis_pkg::*;
  localparam int DEPTH = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [4:0]  fld_enable;
  pmis_event_t ev;
  pmis_level_t lvl;
  pmis_rdclr_t rdclr;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          mismatches, n_tests, cyc;
  logic [31:0] seed = 32'd94603;
  logic [1:0]  m_cmd;
  logic [4:0]  m_dev, m_fld;
  logic        m_rxl, m_fcl, m_rf;
  logic [15:0] ptr [32];
  logic [15:0] mem [32][DEPTH];
  always #5 clk = ~clk;
  pmis_top #(.EXT_DEPTH(DEPTH)) pmis_top_inst (.clk(clk), .rst(rst),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fld_enable(fld_enable), .ev(ev), .lvl(lvl), .rdclr(rdclr));
  pmis_host pmis_host_inst (.clk(clk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ---------------------------------------------------------------
  // model and helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic ok(input logic [4:0] d);
    return d == `PMIS_DEV_VEND || d == `PMIS_DEV_MMD3 || d == `PMIS_DEV_MMD7;
  endfunction : ok
  task automatic model_reset;
    m_cmd = 2'h0;
    m_dev = 5'h0;
    m_fld = 5'h0;
    {m_rxl, m_fcl, m_rf} = 3'h0;
    for (int i = 0; i < 32; i++) begin
      ptr[i] = 16'h0;
      for (int j = 0; j < DEPTH; j++) mem[i][j] = 16'h0;
    end
  endtask : model_reset
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    logic [31:0] r;
    pmis_host_inst.xfer(i, 1'b1, d, r);
    if (i == `PMIS_IDX_EAC) begin
      m_cmd = d[15:14];
      m_dev = d[4:0];
    end else if (i == `PMIS_IDX_EAD && ok(m_dev)) begin
      if (m_cmd == `PMIS_CMD_ADDR) ptr[m_dev] = d;
      else begin
        if (ptr[m_dev] < DEPTH) mem[m_dev][ptr[m_dev][1:0]] = d;
        if (m_cmd[1]) ptr[m_dev]++;
      end
    end
  endtask : wr
  task automatic rd(input logic [5:0] i);
    logic [31:0] r, e;
    e = 32'h0;
    case (i)
      `PMIS_IDX_EAC: e = {16'h0, m_cmd, 9'h0, m_dev};
      `PMIS_IDX_EAD: e = !ok(m_dev) ? 32'h0 : m_cmd == `PMIS_CMD_ADDR ?
        {16'h0, ptr[m_dev]} : ptr[m_dev] < DEPTH ?
        {16'h0, mem[m_dev][ptr[m_dev][1:0]]} : 32'h0;
      `PMIS_IDX_FLD: e = {23'h0, m_fld, 4'h0};
      `PMIS_IDX_SUM: e = {17'h0, lvl.mdix_swapped, m_rxl, lvl.pol_inverted,
        m_fcl, lvl.sig_detect, lvl.descr_lock, lvl.page_rcvd,
        lvl.intr_pending, m_rf, lvl.jabber & lvl.speed_10, lvl.an_done,
        lvl.mii_loopback, lvl.full_duplex, lvl.speed_10, lvl.link_up};
      default: e = 32'h0;
    endcase
    pmis_host_inst.xfer(i, 1'b0, 16'h0, r);
    `CHK(hresp, 1'b0)
    if (i == `PMIS_IDX_SUM) begin
      `CHK(r[31:15], e[31:15])
      `CHK(r[14:9], e[14:9])
      `CHK(r[8:4], e[8:4])
      `CHK(r[3:0], e[3:0])
    end else if (i == `PMIS_IDX_FLD) begin
      `CHK(r, e)
    end else begin
      `CHK(r, e)
    end
    if (i == `PMIS_IDX_EAD && ok(m_dev) && m_cmd == `PMIS_CMD_INC_RW)
      ptr[m_dev]++;
    if (i == `PMIS_IDX_FLD) m_fld = 5'h0;
  endtask : rd
  // events, clears and levels applied while the bus is idle
  task automatic ev_step;
    logic [31:0] e, c, l;
    logic        en;
    e = rnd();
    c = rnd();
    l = rnd();
    en = l[20] | l[21];
    ev <= pmis_event_t'(e[7:0]);
    rdclr <= pmis_rdclr_t'(c[2:0]);
    lvl <= pmis_level_t'(l[11:0]);
    fld_enable <= l[16:12];
    // a low enable must freeze every latch
    ce <= en;
    @(posedge clk);
    ev <= '0;
    rdclr <= '0;
    ce <= 1'b1;
    if (en) begin
      m_fld = m_fld | (e[4:0] & l[16:12]);
      m_rxl = (m_rxl & !c[2]) | e[7];
      m_fcl = (m_fcl & !c[1]) | e[6];
      m_rf = (m_rf & !c[0]) | e[5];
    end
    // spacer edge so a following step never reassigns in this step
    @(posedge clk);
  endtask : ev_step
  task automatic wrap_up;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    logic [4:0]  devs [5];
    logic [31:0] x;
    devs = '{5'h1f, 5'h03, 5'h07, 5'h05, 5'h00};
    fld_enable = 5'h0;
    ev = '0;
    rdclr = '0;
    lvl = pmis_level_t'(12'h002);
    model_reset();
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 12; i < 18; i++) rd(6'(i));
    // unmapped place takes no write
    wr(6'h11, 16'hffff);
    rd(6'h11);
    for (int n = 0; n < 700; n++) begin
      x = rnd();
      case (x[2:0])
        3'h0: wr(`PMIS_IDX_EAC, {x[9:8], x[30:22], devs[x[5:3] % 5]});
        3'h1: wr(`PMIS_IDX_EAD, m_cmd == 2'h0 ? {13'h0, x[5:3]} : x[31:16]);
        3'h2, 3'h3: rd(`PMIS_IDX_EAD);
        3'h4: rd(6'(12 + x[5:3] % 6));
        3'h5: ev_step();
        3'h6: rd(`PMIS_IDX_SUM);
        default: rd(`PMIS_IDX_FLD);
      endcase
    end
    // second reset in mid-run clears latches and pointers
    ev_step();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    model_reset();
    @(posedge clk);
    for (int i = 13; i < 17; i++) rd(6'(i));
    wrap_up();
  end
endmodule : testbench
